// >>> rtl/ppa_top.sv
// Purpose: parallel port address, pin enable, chip select and buffer status logic
// Assumes: register port strobes one cycle, read data one cycle later
// Notes:   mode, transfer and strobe timing come from outside as levels
`timescale 1ns/10ps
`default_nettype none

module ppa_top
    import ppa_pkg::*;
#(
    parameter int BUF_W = 8
) (
    // clock, reset, enable
    input  wire logic               core_clk,
    input  wire logic               nrst,
    input  wire logic               ce,
    // register port
    input  wire logic [7:0]         reg_addr,
    input  wire logic [ppa_pkg::REG_W-1:0] reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [ppa_pkg::REG_W-1:0] reg_rdata,
    // external buffer side
    input  wire logic [1:0]         ext_idx,
    input  wire logic               ext_wr,
    input  wire logic [BUF_W-1:0]   ext_wdata,
    input  wire logic               ext_rd,
    output logic [BUF_W-1:0]        ext_rdata,
    // mode and strobe levels
    input  wire logic               xfer_active,
    input  wire logic               cs_mode,
    input  wire logic               latch_mode,
    input  wire logic               latch_hi,
    input  wire logic               latch_lo,
    // general purpose I/O
    input  wire logic [15:0]        gpio_out,
    input  wire logic [15:0]        gpio_oe,
    // pads and selects
    output logic [15:0]             address_pad_out,
    output logic [15:0]             address_pad_oe,
    output logic                    chip_select_one,
    output logic                    chip_select_two,
    // interrupt
    output logic                    irq
);
    import ppa_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [15:0]      port_address,      next_port_address;
    logic [15:0]      port_pin_enable,   next_port_pin_enable;
    logic [BUF_W-1:0] in_buf  [NBUF];
    logic [BUF_W-1:0] next_in_buf [NBUF];
    logic [BUF_W-1:0] out_buf [NBUF];
    logic [BUF_W-1:0] next_out_buf [NBUF];
    logic [3:0]       input_buffer_unread, next_input_buffer_unread;
    logic [3:0]       output_buffer_sent,  next_output_buffer_sent;
    logic             input_overflow_flag,   next_input_overflow_flag;
    logic             output_underflow_flag, next_output_underflow_flag;
    logic [3:0]       irq_status, next_irq_status;
    logic [3:0]       irq_mask,   next_irq_mask;
    logic [REG_W-1:0] next_reg_rdata;
    logic [BUF_W-1:0] next_ext_rdata;
    logic [REG_W-1:0] status_word;
    logic [3:0]       events;
    logic             sw_in_rd, sw_out_wr;
    logic [1:0]       sw_idx;

    // ----------------------------------------------------------------
    // decode and status word
    // ----------------------------------------------------------------
    assign sw_idx    = reg_addr[3:2];
    assign sw_in_rd  = reg_rd && reg_addr[7:4] == OFS_IN_BUF0[7:4] && reg_addr[1:0] == 2'h0;
    assign sw_out_wr = reg_wr && reg_addr[7:4] == OFS_OUT_BUF0[7:4] && reg_addr[1:0] == 2'h0;

    always_comb begin
        status_word = '0;
        // full only when all hold data
        status_word[ST_IN_FULL] = &input_buffer_unread;
        status_word[ST_IN_OVF]  = input_overflow_flag;
        status_word[ST_IN_LSB +: 4] = input_buffer_unread;
        status_word[ST_OUT_EMPTY] = &output_buffer_sent;
        status_word[ST_OUT_UNF]   = output_underflow_flag;
        status_word[ST_OUT_LSB +: 4] = output_buffer_sent;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_port_address          = port_address;
        next_port_pin_enable       = port_pin_enable;
        next_in_buf                = in_buf;
        next_out_buf               = out_buf;
        next_input_buffer_unread   = input_buffer_unread;
        next_output_buffer_sent    = output_buffer_sent;
        next_input_overflow_flag   = input_overflow_flag;
        next_output_underflow_flag = output_underflow_flag;
        next_irq_status            = irq_status;
        next_irq_mask              = irq_mask;
        next_reg_rdata             = '0;
        next_ext_rdata             = '0;
        events                     = '0;

        // software writes
        if (reg_wr) begin
            case (reg_addr)
                OFS_ADDRESS:  next_port_address = reg_wdata;
                OFS_PIN_EN:   next_port_pin_enable = reg_wdata;
                OFS_BUF_STATUS: begin
                    if (!reg_wdata[ST_IN_OVF]) begin
                        next_input_overflow_flag = 1'b0;
                    end
                    if (!reg_wdata[ST_OUT_UNF]) begin
                        next_output_underflow_flag = 1'b0;
                    end
                end
                OFS_IRQ_MASK: next_irq_mask = reg_wdata[3:0];
                default: ;
            endcase
        end

        // software reads
        if (reg_rd) begin
            case (reg_addr)
                OFS_ADDRESS:    next_reg_rdata = port_address;
                OFS_PIN_EN:     next_reg_rdata = port_pin_enable;
                OFS_BUF_STATUS: next_reg_rdata = status_word;
                OFS_IRQ_STATUS: begin
                    next_reg_rdata  = {{(REG_W-4){1'b0}}, irq_status};
                    next_irq_status = '0;
                end
                OFS_IRQ_MASK:   next_reg_rdata = {{(REG_W-4){1'b0}}, irq_mask};
                default:        next_reg_rdata = '0;
            endcase
        end
        if (sw_in_rd) begin
            next_reg_rdata = {{(REG_W-BUF_W){1'b0}}, in_buf[sw_idx]};
            next_input_buffer_unread[sw_idx] = 1'b0;
        end

        if (ext_wr) begin
            if (input_buffer_unread[ext_idx]) begin
                next_input_overflow_flag = 1'b1;
                events[IRQ_OVF]          = 1'b1;
            end else begin
                next_in_buf[ext_idx] = ext_wdata;
                // fill sets unread, wins over clear
                next_input_buffer_unread[ext_idx] = 1'b1;
            end
        end
        if (ext_rd) begin
            if (output_buffer_sent[ext_idx]) begin
                next_output_underflow_flag = 1'b1;
                events[IRQ_UNF]            = 1'b1;
            end else begin
                next_ext_rdata = out_buf[ext_idx];
                next_output_buffer_sent[ext_idx] = 1'b1;
            end
        end

        // late so new data is not marked sent by a same-cycle drain
        if (sw_out_wr) begin
            next_out_buf[sw_idx] = reg_wdata[BUF_W-1:0];
            next_output_buffer_sent[sw_idx] = 1'b0;
        end

        events[IRQ_IN_FULL]   = (&next_input_buffer_unread) && !(&input_buffer_unread);
        events[IRQ_OUT_EMPTY] = (&next_output_buffer_sent) && !(&output_buffer_sent);
        // set wins over read clear
        next_irq_status = next_irq_status | events;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            port_address          <= RST_ADDRESS;
            port_pin_enable       <= RST_PIN_EN;
            for (int i = 0; i < NBUF; i++) begin
                in_buf[i]  <= '0;
                out_buf[i] <= '0;
            end
            input_buffer_unread   <= RST_UNREAD;
            output_buffer_sent    <= RST_SENT;
            input_overflow_flag   <= 1'b0;
            output_underflow_flag <= 1'b0;
            irq_status            <= '0;
            irq_mask              <= RST_IRQ_MASK;
            reg_rdata             <= '0;
            ext_rdata             <= '0;
        end else if (ce) begin
            port_address          <= next_port_address;
            port_pin_enable       <= next_port_pin_enable;
            in_buf                <= next_in_buf;
            out_buf               <= next_out_buf;
            input_buffer_unread   <= next_input_buffer_unread;
            output_buffer_sent    <= next_output_buffer_sent;
            input_overflow_flag   <= next_input_overflow_flag;
            output_underflow_flag <= next_output_underflow_flag;
            irq_status            <= next_irq_status;
            irq_mask              <= next_irq_mask;
            reg_rdata             <= next_reg_rdata;
            ext_rdata             <= next_ext_rdata;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // chip select one from bit 14
    assign chip_select_one = port_address[BIT_CS1];
    // chip select two from bit 15
    assign chip_select_two = port_address[BIT_CS2];
    assign irq             = |(irq_status & irq_mask);

    ppa_pad_mux u_pad_mux (
        .pin_en      (port_pin_enable),
        .addr        (port_address),
        .xfer_active (xfer_active),
        .cs_mode     (cs_mode),
        .latch_mode  (latch_mode),
        .latch_hi    (latch_hi),
        .latch_lo    (latch_lo),
        .gpio_out    (gpio_out),
        .gpio_oe     (gpio_oe),
        .pad_out     (address_pad_out),
        .pad_oe      (address_pad_oe)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_addr_write;
        ce && reg_wr && reg_addr == OFS_ADDRESS;
    endsequence

    sequence s_empty_read;
        ce && ext_rd && output_buffer_sent[ext_idx];
    endsequence

    addr_hold_a: assert property (s_addr_write |=> port_address[13:0] == $past(reg_wdata[13:0]))
        else $error("address register did not take written value");

    cs_one_a: assert property (s_addr_write |=> chip_select_one == $past(reg_wdata[BIT_CS1]))
        else $error("chip select one does not follow bit 14");

    cs_two_idle_a: assert property (cs_mode && port_pin_enable[15] && !port_address[BIT_CS2]
        |-> !address_pad_out[15] && !chip_select_two)
        else $error("chip select two active with bit 15 clear");

    top_pad_fn_a: assert property (port_pin_enable[14] && cs_mode && xfer_active
        |-> address_pad_oe[14] && address_pad_out[14] == port_address[14])
        else $error("pad 14 not driven by chip select one");

    top_pad_io_a: assert property (port_pin_enable[15:14] == 2'h0
        |-> address_pad_out[15:14] == gpio_out[15:14] && address_pad_oe[15:14] == gpio_oe[15:14])
        else $error("top pads not returned to I/O");

    mid_pad_a: assert property (((address_pad_out[13:2] ^ port_address[13:2]) & port_pin_enable[13:2])
        == 12'h000 && ((address_pad_out[13:2] ^ gpio_out[13:2]) & ~port_pin_enable[13:2]) == 12'h000)
        else $error("middle pad source wrong");

    low_pad_fn_a: assert property (port_pin_enable[0] && latch_mode |-> address_pad_out[0] == latch_lo)
        else $error("pad 0 not carrying low latch strobe");

    low_pad_io_a: assert property (port_pin_enable[1:0] == 2'h0
        |-> address_pad_out[1:0] == gpio_out[1:0] && address_pad_oe[1:0] == gpio_oe[1:0])
        else $error("low pads not returned to I/O");

    reset_clear_a: assert property (disable iff (1'b0) !nrst |=> port_address == 16'h0000
        && port_pin_enable == 16'h0000 && address_pad_oe == gpio_oe)
        else $error("port state not clear after reset");

    in_full_a: assert property (ce && reg_rd && reg_addr == OFS_BUF_STATUS
        |=> reg_rdata[ST_IN_FULL] == $past(&input_buffer_unread))
        else $error("input full flag wrong");

    unread_clr_a: assert property (ce && sw_in_rd && !(ext_wr && ext_idx == sw_idx)
        |=> !input_buffer_unread[$past(sw_idx)])
        else $error("input unread flag not cleared by read");

    out_empty_a: assert property (ce && reg_rd && reg_addr == OFS_BUF_STATUS
        |=> reg_rdata[ST_OUT_EMPTY] == $past(&output_buffer_sent))
        else $error("output empty flag wrong");

    unf_set_a: assert property (s_empty_read |=> output_underflow_flag)
        else $error("underflow flag not set");
    unf_stick_a: assert property (output_underflow_flag
        && !(ce && reg_wr && reg_addr == OFS_BUF_STATUS && !reg_wdata[ST_OUT_UNF])
        |=> output_underflow_flag)
        else $error("underflow flag cleared without a zero write");

endmodule // ppa_top

`default_nettype wire

// >>> rtl/ppa_pkg.sv
// Purpose: constants for the parallel port address, pin enable and buffer status block
// Assumes: 16-bit register port, byte offsets, four byte buffers each way
// Notes:   all offsets and field positions live here, with reset values for address, pin enable, irq mask, unread and sent

package ppa_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_ADDRESS    = 8'h00;
    localparam logic [7:0] OFS_PIN_EN     = 8'h04;
    localparam logic [7:0] OFS_BUF_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h10;
    localparam logic [7:0] OFS_IN_BUF0    = 8'h20;
    localparam logic [7:0] OFS_OUT_BUF0   = 8'h30;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BIT_CS2       = 15;
    localparam int BIT_CS1       = 14;
    localparam int ST_IN_FULL    = 15;
    localparam int ST_IN_OVF     = 14;
    localparam int ST_IN_LSB     = 8;
    localparam int ST_OUT_EMPTY  = 7;
    localparam int ST_OUT_UNF    = 6;
    localparam int ST_OUT_LSB    = 0;
    localparam int IRQ_IN_FULL   = 0;
    localparam int IRQ_OUT_EMPTY = 1;
    localparam int IRQ_OVF       = 2;
    localparam int IRQ_UNF       = 3;

    // ----------------------------------------------------------------
    // sizes and reset values
    // ----------------------------------------------------------------
    localparam int          NBUF          = 4;
    localparam int          REG_W         = 16;
    localparam logic [15:0] RST_ADDRESS   = 16'h0000;
    localparam logic [15:0] RST_PIN_EN    = 16'h0000;
    localparam logic [3:0]  RST_IRQ_MASK  = 4'h0;
    localparam logic [3:0]  RST_UNREAD    = 4'h0;
    localparam logic [3:0]  RST_SENT      = 4'hF;

endpackage

// >>> rtl/ppa_pad_mux.sv
// Purpose: per-pad choice between port function and general purpose I/O
// Assumes: pad enables and address come from registers of the parent, mode and strobe levels from its inputs
// Notes:   one generate loop, one pad per iteration
`timescale 1ns/10ps
`default_nettype none

module ppa_pad_mux (
    // port function sources
    input  wire logic [15:0] pin_en,
    input  wire logic [15:0] addr,
    input  wire logic        xfer_active,
    input  wire logic        cs_mode,
    input  wire logic        latch_mode,
    input  wire logic        latch_hi,
    input  wire logic        latch_lo,
    // general purpose I/O
    input  wire logic [15:0] gpio_out,
    input  wire logic [15:0] gpio_oe,
    // pads
    output logic      [15:0] pad_out,
    output logic      [15:0] pad_oe
);

    // ----------------------------------------------------------------
    // pad selection
    // ----------------------------------------------------------------
    for (genvar i = 0; i < 16; i++) begin : g_pad
        logic fn_val;
        if (i >= 14) begin : g_cs
            assign fn_val = cs_mode ? (addr[i] & xfer_active) : addr[i];
        end else if (i == 1) begin : g_lh
            assign fn_val = latch_mode ? latch_hi : addr[i];
        end else if (i == 0) begin : g_ll
            assign fn_val = latch_mode ? latch_lo : addr[i];
        end else begin : g_ad
            assign fn_val = addr[i];
        end
        assign pad_out[i] = pin_en[i] ? fn_val : gpio_out[i];
        assign pad_oe[i]  = pin_en[i] ? 1'b1 : gpio_oe[i];
    end

endmodule // ppa_pad_mux

`default_nettype wire

// >>> test/ppa_ext_model.sv
// Purpose: far-side peripheral issuing buffer transfers
// Assumes: the bench asks for one transfer at a time
// Notes:   released index and data lines show the inverse of their last value, strobes go low
`timescale 1ns/10ps
`default_nettype none

module ppa_ext_model (
    // clock
    input  wire logic       core_clk,
    // buffer side
    output logic      [1:0] ext_idx,
    output logic            ext_wr,
    output logic      [7:0] ext_wdata,
    output logic            ext_rd
);
    initial begin
        ext_idx   = 2'h0;
        ext_wr    = 1'b0;
        ext_wdata = 8'h00;
        ext_rd    = 1'b0;
    end

    task automatic xfer(input logic rd, input logic [1:0] idx, input logic [7:0] d);
        @(posedge core_clk);
        ext_idx   <= idx;
        ext_wdata <= d;
        ext_wr    <= !rd;
        ext_rd    <= rd;
        @(posedge core_clk);
        ext_wr    <= 1'b0;
        ext_rd    <= 1'b0;
        ext_idx   <= ~idx;
        ext_wdata <= ~d;
        @(posedge core_clk);
    endtask
endmodule // ppa_ext_model
`default_nettype wire

// >>> test/tb.sv
// Purpose: self-checking bench for the port address block
// Assumes: ce driven by the bench, default buffer width
// Notes:   read results are checked from queues by a monitor
`timescale 1ns/10ps
`default_nettype none

module tb;
    import ppa_pkg::*;
    logic        core_clk, nrst, ce, reg_wr, reg_rd, ext_wr, ext_rd, rd_d, erd_d;
    logic        xfer_active, cs_mode, latch_mode, latch_hi, latch_lo;
    logic        chip_select_one, chip_select_two, irq;
    logic [7:0]  reg_addr, ext_wdata, ext_rdata;
    logic [1:0]  ext_idx;
    logic [15:0] reg_wdata, reg_rdata, gpio_out, gpio_oe, pad_out, pad_oe;
    logic [15:0] lfsr, ep, eo, pe, ad;
    logic [15:0] rq[$];
    logic [7:0]  eq[$];
    int          err_count, checks, cyc;

    ppa_top i_ppa_top (
        .core_clk(core_clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_idx(ext_idx), .ext_wr(ext_wr), .ext_wdata(ext_wdata), .ext_rd(ext_rd),
        .ext_rdata(ext_rdata), .xfer_active(xfer_active), .cs_mode(cs_mode),
        .latch_mode(latch_mode), .latch_hi(latch_hi), .latch_lo(latch_lo),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .address_pad_out(pad_out),
        .address_pad_oe(pad_oe), .chip_select_one(chip_select_one),
        .chip_select_two(chip_select_two), .irq(irq));
    ppa_ext_model i_ppa_ext_model (
        .core_clk(core_clk), .ext_idx(ext_idx), .ext_wr(ext_wr),
        .ext_wdata(ext_wdata), .ext_rd(ext_rd));

    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // one register cycle; a read notes its expected data
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= w;
        reg_rd    <= !w;
        if (!w) rq.push_back(d);
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask

    task automatic ext(input logic rd, input logic [1:0] idx, input logic [7:0] d);
        if (rd) eq.push_back(d);
        i_ppa_ext_model.xfer(rd, idx, d);
    endtask

    task automatic settle();
        @(posedge core_clk);
        #1;
    endtask

    task automatic pads(input logic [15:0] pe, input logic [15:0] ad);
        settle();
        for (int i = 0; i < 16; i++) begin
            ep[i] = pe[i] ? ad[i] : gpio_out[i];
            eo[i] = pe[i] | gpio_oe[i];
        end
        if (cs_mode && !xfer_active) ep[15:14] = ep[15:14] & ~pe[15:14];
        if (latch_mode) ep[1:0] = (pe[1:0] & {latch_hi, latch_lo}) | (~pe[1:0] & gpio_out[1:0]);
        cmp("pad_out", ep, pad_out);
        cmp("pad_oe", eo, pad_oe);
        cmp("selects", {14'h0, ad[15:14]}, {14'h0, chip_select_two, chip_select_one});
    endtask

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // --------------------------------------------------------
    // monitor and timeout
    // --------------------------------------------------------
    always @(posedge core_clk) begin
        rd_d  <= reg_rd;
        erd_d <= ext_rd;
        cyc   <= cyc + 1;
        if (cyc == 4000) begin
            err_count++;
            print_verdict();
        end
    end

    always @(negedge core_clk) begin
        if (rd_d) cmp("reg_rdata", rq.pop_front(), reg_rdata);
        if (erd_d) cmp("ext_rdata", {8'h00, eq.pop_front()}, {8'h00, ext_rdata});
    end

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        nrst        = 1'b0;
        ce          = 1'b1;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        reg_addr    = 8'h00;
        reg_wdata   = 16'h0000;
        xfer_active = 1'b0;
        cs_mode     = 1'b0;
        latch_mode  = 1'b0;
        latch_hi    = 1'b0;
        latch_lo    = 1'b0;
        gpio_out    = 16'hA5C3;
        gpio_oe     = 16'h0F0F;
        lfsr        = 16'h000A;
        rd_d        = 1'b0;
        erd_d       = 1'b0;
        err_count   = 0;
        checks      = 0;
        cyc         = 0;
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        bus(0, OFS_ADDRESS, 16'h0000);
        bus(0, OFS_PIN_EN, 16'h0000);
        bus(0, OFS_BUF_STATUS, 16'h008F);
        bus(0, 8'h14, 16'h0000);
        pads(16'h0000, 16'h0000);
        for (int k = 0; k < 10; k++) begin
            lfsr = nxt(lfsr);
            // top enables are forced on with the select mode (k bit 1), low enables with the latch mode (k bit 2)
            ad   = lfsr ^ {k[3:0], 12'h000};
            pe   = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000
                 : nxt(lfsr) | {k[1], k[1], 12'h000, k[2], k[2]};
            bus(1, OFS_ADDRESS, ad);
            bus(1, OFS_PIN_EN, pe);
            bus(0, OFS_ADDRESS, ad);
            bus(0, OFS_PIN_EN, pe);
            @(posedge core_clk);
            gpio_out    <= ~lfsr;
            gpio_oe     <= {lfsr[7:0], lfsr[15:8]};
            xfer_active <= k[0];
            cs_mode     <= k[1];
            latch_mode  <= k[2];
            latch_hi    <= lfsr[3];
            latch_lo    <= lfsr[2];
            pads(pe, ad);
        end
        // clock enable low: a write must leave no trace
        @(posedge core_clk);
        ce <= 1'b0;
        bus(1, OFS_ADDRESS, 16'hFFFF);
        @(posedge core_clk);
        ce <= 1'b1;
        bus(0, OFS_ADDRESS, ad);
        bus(1, OFS_IRQ_MASK, 16'h0001);
        for (int k = 0; k < 4; k++) ext(0, k[1:0], 8'h5A + k[7:0]);
        bus(0, OFS_BUF_STATUS, 16'h8F8F);
        settle();
        cmp("irq", 16'h0001, {15'h0, irq});
        bus(0, OFS_IRQ_STATUS, 16'h0001);
        ext(0, 2'h0, 8'hEE);
        bus(0, OFS_BUF_STATUS, 16'hCF8F);
        settle();
        cmp("irq", 16'h0000, {15'h0, irq});
        for (int k = 0; k < 4; k++) bus(0, OFS_IN_BUF0 + {k[5:0], 2'b00}, 16'h5A + k[15:0]);
        bus(0, OFS_BUF_STATUS, 16'h408F);
        bus(1, OFS_BUF_STATUS, 16'h0000);
        for (int k = 0; k < 4; k++) bus(1, OFS_OUT_BUF0 + {k[5:0], 2'b00}, 16'hC0 + k[15:0]);
        bus(0, OFS_BUF_STATUS, 16'h0000);
        for (int k = 0; k < 3; k++) ext(1, k[1:0], 8'hC0 + k[7:0]);
        bus(0, OFS_BUF_STATUS, 16'h0007);
        ext(1, 2'h3, 8'hC3);
        bus(0, OFS_BUF_STATUS, 16'h008F);
        ext(1, 2'h1, 8'h00);
        bus(0, OFS_BUF_STATUS, 16'h00CF);
        bus(1, OFS_BUF_STATUS, 16'h0040);
        bus(0, OFS_BUF_STATUS, 16'h00CF);
        bus(1, OFS_BUF_STATUS, 16'h0000);
        bus(0, OFS_BUF_STATUS, 16'h008F);
        bus(0, OFS_IRQ_STATUS, 16'h000E);
        // reset again in mid-run
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        bus(0, OFS_ADDRESS, 16'h0000);
        bus(0, OFS_BUF_STATUS, 16'h008F);
        pads(16'h0000, 16'h0000);
        cmp("irq", 16'h0000, {15'h0, irq});
        settle();
        print_verdict();
    end
endmodule // tb
`default_nettype wire
